// ===== shp_pkg.sv
/*
  shared constants for the strobe host port: address map, pin timing, states.
  assumes one 250 MHz clock (mclk) on both ends and a synchronous active-low reset.
*/
package shp_pkg;
  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned T_CS_TO_STB_NS   = 65;
  localparam int unsigned T_STB_TO_ACK_NS  = 90;
  localparam int unsigned T_STB_WIDTH_NS   = 90;
  localparam int unsigned CS_TO_STB_CYC    = (T_CS_TO_STB_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int unsigned STB_TO_ACK_CYC   = (T_STB_TO_ACK_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned STB_WIDTH_CYC    = (T_STB_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int unsigned CNT_W            = 6;
  localparam logic [CNT_W-1:0] ACK_DELAY   = CNT_W'(4);
  localparam logic [CNT_W-1:0] CS_STB_GAP  = CNT_W'(CS_TO_STB_CYC);
  localparam logic [CNT_W-1:0] STB_HOLD    = CNT_W'(STB_WIDTH_CYC);
  localparam logic [CNT_W-1:0] ACK_TIMEOUT = CNT_W'(63);

  // ----------------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned MAP_DEPTH        = 256;
  localparam logic [7:0] CHAN_LAST         = 8'h7f;
  localparam logic [7:0] GLOBAL_FIRST      = 8'h80;
  localparam logic [7:0] GLOBAL_LAST       = 8'h8e;
  localparam logic [7:0] GLOBAL_EXTRA_CTRL = 8'hc0;
  localparam logic [7:0] TEST_FIRST        = 8'h8f;
  localparam logic [7:0] TEST_LAST         = 8'hfd;
  localparam logic [7:0] DEVICE_IDENTITY   = 8'hfe;
  localparam logic [7:0] DEVICE_REVISION   = 8'hff;
  localparam logic [7:0] DEVICE_IDENTITY_VAL     = 8'h5c;  // arbitrary value
  localparam logic [7:0] DEVICE_REV_VAL    = 8'h03;  // arbitrary value
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [7:0] MAP_ZERO          = 8'h00;

  // ----------------------------------------------------------------------
  // controller registers on avalon (avs_address is decoded against these values as given, not divided by 4)
  // ----------------------------------------------------------------------
  localparam int unsigned AV_ADDR_W        = 4;
  localparam logic [3:0] AV_CMD            = 4'h0;
  localparam logic [3:0] AV_WDATA          = 4'h4;
  localparam logic [3:0] AV_STATUS         = 4'h8;
  localparam logic [3:0] AV_RDATA          = 4'hc;
  localparam int unsigned CMD_ADDR_LSB     = 0;
  localparam int unsigned CMD_WRITE_BIT    = 8;
  localparam int unsigned ST_BUSY_BIT      = 0;
  localparam int unsigned ST_TIMEOUT_BIT   = 1;
  localparam logic [31:0] AV_UNMAPPED      = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    DEV_IDLE = 4'b0001,
    DEV_WAIT = 4'b0010,
    DEV_ACK  = 4'b0100,
    DEV_DONE = 4'b1000
  } shp_dev_state_t;

  typedef enum logic [5:0] {
    HST_IDLE  = 6'b000001,
    HST_ADDR  = 6'b000010,
    HST_LATCH = 6'b000100,
    HST_STRB  = 6'b001000,
    HST_END   = 6'b010000,
    HST_GAP   = 6'b100000
  } shp_host_state_t;
endpackage

// ===== shp_if.sv
/*
  pin bundle between host and device of the strobe host port.
  assumes the testbench resolves the shared data bus from the two enables.
*/
interface shp_if;
  import shp_pkg::*;
  logic              cs_n;
  logic              host_addr_strobe;
  logic              rd_wr_n;
  logic              data_strobe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data_out;
  logic              host_data_oe;
  logic [DATA_W-1:0] dev_data_out;
  logic              dev_data_oe;
  logic [DATA_W-1:0] data_in;
  logic              transfer_ack_n;

  modport device (
    input  cs_n,
    input  host_addr_strobe,
    input  rd_wr_n,
    input  data_strobe_n,
    input  addr,
    input  data_in,
    output dev_data_out,
    output dev_data_oe,
    output transfer_ack_n
  );

  modport host (
    output cs_n,
    output host_addr_strobe,
    output rd_wr_n,
    output data_strobe_n,
    output addr,
    output host_data_out,
    output host_data_oe,
    input  data_in,
    input  transfer_ack_n
  );
endinterface

// ===== shp_device.sv
/*
  device end of the strobe host port with the 8-bit register map.
  assumes the host pins are asynchronous and the data wire is resolved outside.
*/
// Chosen here: the Avalon-MM interface to the registers.
// What this block does
// - strobe plus direction line controls access
// - host presents address at cycle start
// - chip select low, else bus ignored
// - address strobe low captures the address
// - address captured on strobe falling edge
// - direction high before strobe means read
// - direction low with data means write
// - data strobe low starts transfer, drives
// - read: acknowledge low when data valid
// - write: store data, then acknowledge low
// - acknowledge output is active low
// - host ends cycle raising data strobe
// - eight channel blocks of sixteen addresses
// - global registers at 0x80 to 0x8e
// - extra global register at 0xc0
// - 0x8f to 0xfd are test registers
module shp_device
  import shp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  shp_if.device                  pins,
  output logic [DATA_W-1:0]      global_extra_control,
  output logic                   rst_done
);
  import shp_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] cs_sync, as_sync, stb_sync;
  logic [2:0] next_cs_sync, next_as_sync, next_stb_sync;
  logic       cs_low, as_fall, stb_low;

  always_comb begin
    next_cs_sync = {cs_sync[1:0], pins.cs_n};
    next_as_sync = {as_sync[1:0], pins.host_addr_strobe};
    next_stb_sync = {stb_sync[1:0], pins.data_strobe_n};
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_sync <= 3'h7;
      as_sync <= 3'h7;
      stb_sync <= 3'h7;
    end else begin
      cs_sync <= next_cs_sync;
      as_sync <= next_as_sync;
      stb_sync <= next_stb_sync;
    end
  end

  // a change counts once stages two and three agree
  logic cs_state, as_state, stb_state, as_prev;
  logic next_cs_state, next_as_state, next_stb_state;

  always_comb begin
    next_cs_state = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_state;
    next_as_state = (as_sync[1] == as_sync[2]) ? as_sync[2] : as_state;
    next_stb_state = (stb_sync[1] == stb_sync[2]) ? stb_sync[2] : stb_state;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_state <= 1'b1;
      as_state <= 1'b1;
      stb_state <= 1'b1;
      as_prev  <= 1'b1;
    end else begin
      cs_state <= next_cs_state;
      as_state <= next_as_state;
      stb_state <= next_stb_state;
      as_prev  <= as_state;
    end
  end

  always_comb begin
    cs_low  = !cs_state;
    as_fall = as_prev && !as_state;
    stb_low = !stb_state;
  end

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] regs [MAP_DEPTH];
  logic [ADDR_W-1:0] addr_latch, next_addr_latch;
  logic              wr_en;
  logic              is_ro;

  always_comb begin
    next_addr_latch = addr_latch;
    if (cs_low && as_fall) begin
      next_addr_latch = pins.addr;
    end
  end

  // channel blocks, global range except 0x8e, 0xc0 and test range are plain r/w; 0x8e, 0xfe and 0xff are read-only
  always_comb begin
    is_ro = (addr_latch == DEVICE_IDENTITY) || (addr_latch == DEVICE_REVISION)
            || (addr_latch == GLOBAL_LAST);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_latch <= REG_RESET;
      for (int i = 0; i < MAP_DEPTH; i++) begin
        regs[i] <= REG_RESET;
      end
    end else begin
      addr_latch <= next_addr_latch;
      if (wr_en && !is_ro) begin
        regs[addr_latch] <= pins.data_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transfer handshake
  // ----------------------------------------------------------------------
  shp_dev_state_t    st, next_st;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic              is_read, next_is_read;
  logic              ack_n, next_ack_n;
  logic              oe, next_oe;
  logic [DATA_W-1:0] dout, next_dout;
  logic [DATA_W-1:0] rd_val;

  always_comb begin
    unique case (addr_latch)
      DEVICE_IDENTITY: rd_val = DEVICE_IDENTITY_VAL;
      DEVICE_REVISION: rd_val = DEVICE_REV_VAL;
      default:         rd_val = regs[addr_latch];
    endcase
  end

  always_comb begin
    next_st      = st;
    next_cnt     = cnt;
    next_is_read = is_read;
    next_ack_n   = ack_n;
    next_oe      = oe;
    next_dout    = dout;
    wr_en        = 1'b0;
    unique case (st)
      DEV_IDLE: begin
        if (cs_low && stb_low) begin
          next_is_read = pins.rd_wr_n;
          next_cnt     = ACK_DELAY;
          next_st      = DEV_WAIT;
          next_oe      = pins.rd_wr_n;
          next_dout    = rd_val;
        end
      end
      DEV_WAIT: begin
        if (!cs_low || !stb_low) begin
          next_oe = 1'b0;
          next_st = DEV_IDLE;
        end else if (cnt == '0) begin
          wr_en      = !is_read;
          next_dout  = rd_val;
          next_ack_n = 1'b0;
          next_st    = DEV_ACK;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      DEV_ACK: begin
        if (!cs_low || !stb_low) begin
          next_ack_n = 1'b1;
          next_oe    = 1'b0;
          next_st    = DEV_DONE;
        end
      end
      DEV_DONE: begin
        next_st = DEV_IDLE;
      end
      default: begin
        next_st = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st      <= DEV_IDLE;
      cnt     <= '0;
      is_read <= 1'b1;
      ack_n   <= 1'b1;
      oe      <= 1'b0;
      dout    <= REG_RESET;
    end else begin
      st      <= next_st;
      cnt     <= next_cnt;
      is_read <= next_is_read;
      ack_n   <= next_ack_n;
      oe      <= next_oe;
      dout    <= next_dout;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  logic done_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      global_extra_control <= REG_RESET;
      done_q               <= 1'b0;
    end else begin
      global_extra_control <= regs[GLOBAL_EXTRA_CTRL];
      done_q               <= 1'b1;
    end
  end

  assign rst_done            = done_q;
  assign pins.transfer_ack_n = ack_n;
  assign pins.dev_data_oe    = oe;
  assign pins.dev_data_out   = dout;
endmodule

// ===== shp_host.sv
/*
  host end of the strobe host port, ordered by software over avalon-mm.
  assumes the device answers within the acknowledge timeout; one clock.
*/
module shp_host
  import shp_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [AV_ADDR_W-1:0]  avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  shp_if.host                        pins
);
  import shp_pkg::*;

  // ----------------------------------------------------------------------
  // acknowledge synchroniser
  // ----------------------------------------------------------------------
  logic [2:0] ack_sync, next_ack_sync;
  logic       ack_state, next_ack_state;
  always_comb begin
    next_ack_sync  = {ack_sync[1:0], pins.transfer_ack_n};
    next_ack_state = (ack_sync[1] == ack_sync[2]) ? ack_sync[2] : ack_state;
  end

  // ----------------------------------------------------------------------
  // registers and cycle sequencer
  // ----------------------------------------------------------------------
  shp_host_state_t   st, next_st;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [7:0]        addr_r, next_addr_r, wdata_r, next_wdata_r, rdata_r, next_rdata_r;
  logic              dir_wr, next_dir_wr, tmo, next_tmo;
  logic              cs_n, next_cs_n, as_r, next_as_r, stb_n, next_stb_n, oe, next_oe;
  logic              busy;
  logic [31:0]       rdd, next_rdd;
  logic              wrq, next_wrq;
  logic              req;

  always_comb begin
    busy = !st[0];
    req  = (avs_read || avs_write) && wrq;
  end

  always_comb begin
    next_st = st; next_cnt = cnt; next_addr_r = addr_r; next_wdata_r = wdata_r;
    next_rdata_r = rdata_r; next_dir_wr = dir_wr; next_tmo = tmo;
    next_cs_n = cs_n; next_as_r = as_r; next_stb_n = stb_n; next_oe = oe;
    next_rdd = rdd;
    next_wrq = 1'b1;
    if (req) begin
      next_wrq = 1'b0;
      next_rdd = AV_UNMAPPED;
      if (avs_write) begin
        unique case (avs_address)
          AV_CMD: if (!busy) begin
            next_addr_r = avs_writedata[CMD_ADDR_LSB +: ADDR_W];
            next_dir_wr = avs_writedata[CMD_WRITE_BIT];
            next_tmo    = 1'b0;
            next_st     = HST_ADDR;
          end
          AV_WDATA: next_wdata_r = avs_writedata[DATA_W-1:0];
          default: ;
        endcase
      end else begin
        unique case (avs_address)
          AV_CMD:    next_rdd = {23'h0, dir_wr, addr_r};
          AV_WDATA:  next_rdd = {24'h0, wdata_r};
          AV_STATUS: next_rdd = {30'h0, tmo, busy};
          AV_RDATA:  next_rdd = {24'h0, rdata_r};
          default:   next_rdd = AV_UNMAPPED;
        endcase
      end
    end
    unique case (st)
      HST_IDLE: ;
      HST_ADDR: begin
        next_cs_n = 1'b0;
        next_as_r = 1'b1;
        next_cnt  = CS_STB_GAP;
        next_st   = HST_LATCH;
      end
      HST_LATCH: begin
        // strobe stays high long enough for the device's pin filter
        if (cnt < (CS_STB_GAP >> 1)) begin
          next_as_r = 1'b0;
        end
        next_oe   = dir_wr;
        if (cnt == '0) begin
          next_stb_n = 1'b0;
          next_cnt  = ACK_TIMEOUT;
          next_st   = HST_STRB;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      HST_STRB: begin
        // end after acknowledge and the minimum strobe width, or at the acknowledge timeout
        if (!ack_state && ((ACK_TIMEOUT - cnt) >= STB_HOLD)) begin
          next_rdata_r = pins.data_in;
          next_stb_n   = 1'b1;
          next_cs_n    = 1'b1;
          next_oe      = 1'b0;
          next_st      = HST_END;
        end else if (cnt == '0) begin
          next_tmo   = 1'b1;
          next_stb_n = 1'b1;
          next_cs_n = 1'b1;
          next_oe   = 1'b0;
          next_st   = HST_END;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      HST_END: begin
        next_cnt = STB_HOLD;
        next_st  = HST_GAP;
      end
      HST_GAP: begin
        if (ack_state && cnt == '0) begin
          next_st = HST_IDLE;
        end else if (cnt != '0) begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: next_st = HST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_sync <= 3'h7; ack_state <= 1'b1;
      st <= HST_IDLE; cnt <= '0; addr_r <= MAP_ZERO; wdata_r <= MAP_ZERO;
      rdata_r <= MAP_ZERO; dir_wr <= 1'b0; tmo <= 1'b0;
      cs_n <= 1'b1; as_r <= 1'b1; stb_n <= 1'b1; oe <= 1'b0;
      rdd <= AV_UNMAPPED; wrq <= 1'b1;
    end else begin
      ack_sync <= next_ack_sync; ack_state <= next_ack_state;
      st <= next_st; cnt <= next_cnt; addr_r <= next_addr_r; wdata_r <= next_wdata_r;
      rdata_r <= next_rdata_r; dir_wr <= next_dir_wr; tmo <= next_tmo;
      cs_n <= next_cs_n; as_r <= next_as_r; stb_n <= next_stb_n; oe <= next_oe;
      rdd <= next_rdd; wrq <= next_wrq;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign avs_readdata          = rdd;
  assign avs_waitrequest       = wrq;
  assign pins.cs_n             = cs_n;
  assign pins.host_addr_strobe = as_r;
  assign pins.data_strobe_n    = stb_n;
  assign pins.rd_wr_n          = !dir_wr;
  assign pins.addr             = addr_r;
  assign pins.host_data_out    = wdata_r;
  assign pins.host_data_oe     = oe;
endmodule

// ===== shp_properties.sv
/*
  checker for the pin bundle between host and device of the strobe host port.
  assumes one clock mclk, synchronous active-low rst_n, instantiated beside the bundle.
*/
module shp_properties
  import shp_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              cs_n,
  input wire logic              host_addr_strobe,
  input wire logic              rd_wr_n,
  input wire logic              data_strobe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] host_data_out,
  input wire logic              host_data_oe,
  input wire logic [DATA_W-1:0] dev_data_out,
  input wire logic              dev_data_oe,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic              transfer_ack_n
);
  localparam int ACK_MAX   = 22;
  localparam int REL_MAX   = 6;
  localparam int CS_STB_MIN = 17;
  localparam int STB_MIN    = 23;

  // ----------------------------------------------------------------------
  // low-time counters
  // ----------------------------------------------------------------------
  logic [7:0] cs_cnt;
  logic [7:0] next_cs_cnt;
  logic [7:0] stb_cnt;
  logic [7:0] next_stb_cnt;

  always_comb begin
    next_cs_cnt = cs_n ? 8'h00 : cs_cnt + {7'h00, cs_cnt != 8'hff};
    next_stb_cnt = data_strobe_n ? 8'h00 : stb_cnt + {7'h00, stb_cnt != 8'hff};
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_cnt <= 8'h00;
      stb_cnt <= 8'h00;
    end else begin
      cs_cnt <= next_cs_cnt;
      stb_cnt <= next_stb_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_ack_in_time: assert property ($fell(data_strobe_n) && !cs_n |->
    ##[1:ACK_MAX] !transfer_ack_n) else $error("acknowledge late");
  chk_idle_quiet: assert property (cs_n [*6] |->
    transfer_ack_n && !dev_data_oe) else $error("device active while deselected");
  chk_release_fast: assert property ($rose(data_strobe_n) |->
    ##[0:REL_MAX] (transfer_ack_n && !dev_data_oe)) else $error("no release");
  chk_read_drives: assert property (!cs_n && !data_strobe_n && rd_wr_n && !transfer_ack_n
    |-> dev_data_oe) else $error("read acked without data driven");
  chk_write_quiet: assert property (!cs_n && !data_strobe_n && !rd_wr_n
    |-> host_data_oe && !dev_data_oe) else $error("write bus wrong");
  chk_no_contention: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive data");
  chk_cs_lead: assert property ($fell(data_strobe_n) |->
    cs_cnt >= CS_STB_MIN && !host_addr_strobe) else $error("strobe too early");
  chk_strobe_width: assert property ($rose(data_strobe_n) |->
    stb_cnt >= STB_MIN && !$past(transfer_ack_n)) else $error("strobe ended early");
  chk_addr_hold: assert property (!cs_n && !$past(cs_n) |-> $stable(addr))
    else $error("address moved");
  chk_dir_hold: assert property (!data_strobe_n && !$past(data_strobe_n) |->
    $stable(rd_wr_n) && $stable(host_data_out)) else $error("direction moved");

  cover property ($fell(data_strobe_n) && rd_wr_n);
  cover property ($fell(data_strobe_n) && !rd_wr_n);
  cover property ($fell(transfer_ack_n));
endmodule

// ===== strobe_host_port_regmap_tb.sv
/*
  self-checking bench: host and device joined, plus a bench-driven second device.
  assumes the design files of the strobe host port are compiled first.
*/
module strobe_host_port_regmap_tb;
  import shp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  localparam logic [7:0] RW_ADDR [7] = '{8'h00, 8'h0f, 8'h10, 8'h7f, 8'h80, 8'h8d, 8'hc0};
  logic                 mclk;
  logic                 rst_n;
  logic [AV_ADDR_W-1:0] avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [7:0]           gec;
  logic [7:0]           gec2;
  logic                 rst_done;
  logic                 rst_done2;
  logic [7:0]           flt = 8'h5a;
  int                   failures;
  int                   total_checks;

  shp_if bus();
  shp_if bus2();
  assign bus.data_in = bus.dev_data_oe ? bus.dev_data_out
                     : (bus.host_data_oe ? bus.host_data_out : flt);
  assign bus2.data_in = bus2.dev_data_oe ? bus2.dev_data_out
                      : (bus2.host_data_oe ? bus2.host_data_out : ~flt);

  shp_host i_shp_host (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(bus.host));
  shp_device i_shp_device (.mclk(mclk), .rst_n(rst_n), .pins(bus.device),
    .global_extra_control(gec), .rst_done(rst_done));
  shp_device i_shp_device2 (.mclk(mclk), .rst_n(rst_n), .pins(bus2.device),
    .global_extra_control(gec2), .rst_done(rst_done2));
  shp_properties i_shp_properties (.mclk(mclk), .rst_n(rst_n), .cs_n(bus.cs_n),
    .host_addr_strobe(bus.host_addr_strobe), .rd_wr_n(bus.rd_wr_n),
    .data_strobe_n(bus.data_strobe_n), .addr(bus.addr), .host_data_out(bus.host_data_out),
    .host_data_oe(bus.host_data_oe), .dev_data_out(bus.dev_data_out),
    .dev_data_oe(bus.dev_data_oe), .data_in(bus.data_in), .transfer_ack_n(bus.transfer_ack_n));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    flt <= ~flt;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    if (n >= 100) failures++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic port_op(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    logic [31:0] r;
    int          n;
    n = 0;
    if (wr) av_xfer(1'b1, AV_WDATA, {24'h0, d}, r);
    av_xfer(1'b1, AV_CMD, {23'h0, wr, a}, r);
    do begin
      av_xfer(1'b0, AV_STATUS, 32'h0, r);
      n++;
    end while (r[ST_BUSY_BIT] !== 1'b0 && n < 200);
    chk({30'h0, r[ST_TIMEOUT_BIT], r[ST_BUSY_BIT]}, 32'h0);
    av_xfer(1'b0, AV_RDATA, 32'h0, r);
    q = r[7:0];
  endtask

  task automatic raw(input logic cs, input logic [7:0] a, input logic [7:0] s,
                     input logic rw, input logic [7:0] d, output logic [7:0] q,
                     output logic ack);
    ack = 1'b0;
    q = 8'h00;
    @(posedge mclk);
    bus2.cs_n <= ~cs;
    bus2.addr <= a;
    bus2.host_addr_strobe <= 1'b1;
    bus2.rd_wr_n <= rw;
    bus2.host_data_out <= d;
    bus2.host_data_oe <= ~rw;
    repeat (2) @(posedge mclk);
    bus2.host_addr_strobe <= 1'b0;
    repeat (8) @(posedge mclk);
    bus2.addr <= a ^ s;
    repeat (12) @(posedge mclk);
    bus2.data_strobe_n <= 1'b0;
    repeat (30) begin
      @(posedge mclk);
      if (!ack && bus2.transfer_ack_n === 1'b0) begin
        ack = 1'b1;
        q = bus2.data_in;
      end
    end
    bus2.data_strobe_n <= 1'b1;
    bus2.cs_n <= 1'b1;
    bus2.host_data_oe <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({30'h0, bus2.transfer_ack_n, bus2.dev_data_oe}, 32'h2);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    repeat (2) @(posedge mclk);
    #1;
    chk({28'h0, bus.transfer_ack_n, bus.dev_data_oe, bus.cs_n, rst_done}, 32'hb);
    av_xfer(1'b0, 4'h2, 32'h0, r);
    chk(r, AV_UNMAPPED);
    av_xfer(1'b0, AV_STATUS, 32'h0, r);
    chk(r, 32'h0);
  endtask

  task automatic t_map;
    logic [7:0] q;
    foreach (RW_ADDR[i]) begin
      port_op(1'b0, RW_ADDR[i], 8'h00, q);
      chk({24'h0, q}, {24'h0, REG_RESET});
    end
    foreach (RW_ADDR[i]) port_op(1'b1, RW_ADDR[i], RW_ADDR[i] ^ 8'h5a, q);
    foreach (RW_ADDR[i]) begin
      port_op(1'b0, RW_ADDR[i], 8'h00, q);
      chk({24'h0, q}, {24'h0, RW_ADDR[i] ^ 8'h5a});
    end
    chk({24'h0, gec}, {24'h0, 8'hc0 ^ 8'h5a});
    port_op(1'b0, TEST_FIRST, 8'h00, q);
    chk({24'h0, q}, {24'h0, REG_RESET});
    port_op(1'b0, TEST_LAST, 8'h00, q);
    chk({24'h0, q}, {24'h0, REG_RESET});
    port_op(1'b1, GLOBAL_LAST, 8'h77, q);
    port_op(1'b0, GLOBAL_LAST, 8'h00, q);
    chk({24'h0, q}, {24'h0, REG_RESET});
    port_op(1'b1, DEVICE_IDENTITY, 8'h77, q);
    port_op(1'b0, DEVICE_IDENTITY, 8'h00, q);
    chk({24'h0, q}, {24'h0, DEVICE_IDENTITY_VAL});
    port_op(1'b0, DEVICE_REVISION, 8'h00, q);
    chk({24'h0, q}, {24'h0, DEVICE_REV_VAL});
  endtask

  task automatic t_raw;
    logic [7:0] q;
    logic       ack;
    raw(1'b0, 8'h21, 8'h01, 1'b0, 8'h6b, q, ack);
    chk({31'h0, ack}, 32'h0);
    raw(1'b1, 8'h21, 8'h01, 1'b0, 8'h6b, q, ack);
    chk({31'h0, ack}, 32'h1);
    raw(1'b1, 8'h21, 8'h02, 1'b1, 8'h00, q, ack);
    chk({23'h0, ack, q}, {23'h0, 1'b1, 8'h6b});
    chk({23'h0, rst_done2, gec2}, {23'h0, 1'b1, REG_RESET});
  endtask

  // ----------------------------------------------------------------------
  // main sequence and verdict
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    total_checks = 0;
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    bus2.cs_n = 1'b1;
    bus2.host_addr_strobe = 1'b0;
    bus2.rd_wr_n = 1'b1;
    bus2.data_strobe_n = 1'b1;
    bus2.addr = 8'h00;
    bus2.host_data_out = 8'h00;
    bus2.host_data_oe = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_map();
    t_raw();
    print_verdict();
  end

  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule
